//--- include/ahfs_pkg.sv
// shared types and constants of the host-side flow control, status and strobe logic
`default_nettype none
package ahfs_pkg;

  // ****************************************
  // widths and depths
  // ****************************************
  localparam int unsigned AD_WIDTH = 32;
  localparam int unsigned SBA_WIDTH = 8;
  localparam int unsigned ST_WIDTH = 3;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned PTR_WIDTH = 5;

  // ****************************************
  // codes and reset values
  // ****************************************
  localparam logic [2:0] ST_FRAME_GO = 3'h7;      // status value that lets a frame start
  localparam logic [2:0] ST_RESET = 3'h7;
  localparam logic [7:0] SBA_IDLE = 8'hFF;        // sideband idle pattern
  localparam logic [31:0] AD_RESET = 32'h0000_0000;

  // operating mode of the port
  typedef enum logic [1:0] {
    MODE_FRAME = 2'b00,
    MODE_PIPE = 2'b01,
    MODE_SBA = 2'b10
  } ahfs_mode_t;

  // burst state, gray along idle-read and idle-write
  typedef enum logic [1:0] {
    FSM_IDLE = 2'b00,
    FSM_READ = 2'b01,
    FSM_WRITE = 2'b10
  } ahfs_fsm_t;

  // one queued word: read return or fast write data
  typedef struct packed {
    logic isWrite;
    logic last;
    logic [AD_WIDTH-1:0] data;
  } ahfs_word_t;

  localparam int unsigned WORD_WIDTH = $bits(ahfs_word_t);

  // strobe pins, true and complement for both halves and the oe
  typedef struct packed {
    logic stb0;
    logic stb0N;
    logic stb1;
    logic stb1N;
    logic oe;
  } ahfs_strobe_t;

endpackage

`default_nettype wire

//--- hdl/ahfs_host.sv
// host end of the port: word fifo, flow-controlled burst engine, status bus and strobes
//
// How it works
// - read-buffer-full blocks starting a new read return; a running one finishes
// - buffer-full pins are looked at only on the cycle-start edge of the link clock
// - buffer-full pins are ignored while the port runs frame-based transactions
// - write-buffer-full stops driving fast write data toward the master
// - in frame mode status 111 lets the master start a frame
// - low-half strobe pair is driven by the host while it sources data
// - high-half strobe pair is driven by the host while it sources data
// - sideband bus carries no addresses during frame-based operation
// - frame pin is driven low only to bracket a fast write
// - sideband requests are taken while the data bus is busy
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// word fifo
// ****************************************
module ahfs_fifo #(
  parameter int unsigned WIDTH = 34,
  parameter int unsigned DEPTH = 32,
  parameter int unsigned AW = 5
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  typedef struct packed {
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic notFull;
  } ahfs_fifo_state_t;

  ahfs_fifo_state_t s_q, s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic doWr, doRd;

  // ready comes from a register so the source sees an honest full
  always_comb begin
    doWr = inValid & s_q.notFull;
    doRd = outReady & (s_q.count != '0);
    s_d = s_q;
    if (doWr) s_d.wrPtr = s_q.wrPtr + 1'b1;
    if (doRd) s_d.rdPtr = s_q.rdPtr + 1'b1;
    s_d.count = s_q.count + {{AW{1'b0}}, doWr} - {{AW{1'b0}}, doRd};
    s_d.notFull = (s_d.count != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_q <= '{wrPtr: '0, rdPtr: '0, count: '0, notFull: 1'b1};
    end else begin
      s_q <= s_d;
    end
    if (doWr) mem[s_q.wrPtr] <= inData;
  end

  assign inReady = s_q.notFull;
  assign outValid = (s_q.count != '0);
  assign outData = mem[s_q.rdPtr];
endmodule // ahfs_fifo

// ****************************************
// host engine
// ****************************************
module ahfs_host (
  input wire logic clock,
  input wire logic srst,
  input wire ahfs_pkg::ahfs_mode_t mode,
  input wire logic linkClk,
  input wire logic rbfN,
  input wire logic wbfN,
  input wire logic [ahfs_pkg::SBA_WIDTH-1:0] sbaIn,
  input wire logic grantReq,
  input wire logic frameGrant,
  input wire logic [ahfs_pkg::ST_WIDTH-1:0] stCode,
  input wire logic wordValid,
  output logic wordReady,
  input wire ahfs_pkg::ahfs_word_t wordIn,
  output logic [ahfs_pkg::AD_WIDTH-1:0] adOut,
  output logic adOe,
  output ahfs_pkg::ahfs_strobe_t adStb,
  output logic frameN,
  output logic frameOe,
  output logic gntN,
  output logic [ahfs_pkg::ST_WIDTH-1:0] stOut,
  output logic sbaReq,
  output logic [ahfs_pkg::SBA_WIDTH-1:0] sbaAddr
);
  import ahfs_pkg::*;

  typedef struct packed {
    ahfs_fsm_t fsm;
    logic [1:0] lnkS;
    logic lnkPrev;
    logic [1:0] rbfS;
    logic [1:0] wbfS;
    logic [SBA_WIDTH-1:0] sbaS1;
    logic [SBA_WIDTH-1:0] sbaS2;
    logic rbfSeen;
    logic wbfSeen;
    logic lastSent;
    logic [AD_WIDTH-1:0] ad;
    logic adOe;
    ahfs_strobe_t stb;
    logic frameN;
    logic gntN;
    logic [ST_WIDTH-1:0] st;
    logic sbaReq;
    logic [SBA_WIDTH-1:0] sbaAddr;
  } ahfs_state_t;

  ahfs_state_t s_q, s_d;
  ahfs_word_t head;
  logic [WORD_WIDTH-1:0] headBits;
  logic headValid, pop, rise, flowOn, rbfFull, wbfFull;

  ahfs_fifo #(.WIDTH(WORD_WIDTH), .DEPTH(FIFO_DEPTH), .AW(PTR_WIDTH)) u_fifo (
    .clock(clock),
    .srst(srst),
    .inValid(wordValid),
    .inReady(wordReady),
    .inData(wordIn),
    .outValid(headValid),
    .outReady(pop),
    .outData(headBits)
  );
  assign head = ahfs_word_t'(headBits);

  // strobe pair flip and drive, shared by read and write bursts
  function automatic ahfs_strobe_t stbFlip(input ahfs_strobe_t cur);
    ahfs_strobe_t nxt;
    nxt.stb0 = ~cur.stb0;
    nxt.stb0N = cur.stb0;
    nxt.stb1 = ~cur.stb1;
    nxt.stb1N = cur.stb1;
    nxt.oe = 1'b1;
    return nxt;
  endfunction

  // cycle starts at a sampled rising edge of the link clock
  assign rise = s_q.lnkS[1] & ~s_q.lnkPrev;
  assign flowOn = (mode != MODE_FRAME);
  assign rbfFull = flowOn & s_q.rbfSeen;
  assign wbfFull = flowOn & s_q.wbfSeen;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    pop = 1'b0;
    // two-flop synchronisers on every pin from the link
    s_d.lnkS = {s_q.lnkS[0], linkClk};
    s_d.lnkPrev = s_q.lnkS[1];
    s_d.rbfS = {s_q.rbfS[0], rbfN};
    s_d.wbfS = {s_q.wbfS[0], wbfN};
    s_d.sbaS1 = sbaIn;
    s_d.sbaS2 = s_q.sbaS1;
    // flags caught at cycle start only, low means full
    if (rise) begin
      s_d.rbfSeen = ~s_q.rbfS[1];
      s_d.wbfSeen = ~s_q.wbfS[1];
    end
    s_d.sbaReq = 1'b0;
    // sideband runs beside the data engine, never in frame mode
    if (rise && mode == MODE_SBA && s_q.sbaS2 != SBA_IDLE) begin
      s_d.sbaReq = 1'b1;
      s_d.sbaAddr = s_q.sbaS2;
    end
    // arbiter status: 111 opens a frame in frame mode
    s_d.gntN = ~(grantReq | (mode == MODE_FRAME && frameGrant));
    s_d.st = (mode == MODE_FRAME && frameGrant) ? ST_FRAME_GO : stCode;
    // burst engine, steps once per link cycle
    if (rise) begin
      unique case (s_q.fsm)
        FSM_IDLE: begin
          // new read waits for room, new write for room
          if (headValid && !head.isWrite && !rbfFull) begin
            s_d.fsm = FSM_READ;
          end else if (headValid && head.isWrite && !wbfFull) begin
            s_d.fsm = FSM_WRITE;
            s_d.frameN = 1'b0;
          end
          if (s_d.fsm != FSM_IDLE) begin
            pop = 1'b1;
            s_d.ad = head.data;
            s_d.adOe = 1'b1;
            s_d.stb = stbFlip(s_q.stb);
            s_d.lastSent = head.last;
          end
        end
        FSM_READ, FSM_WRITE: begin
          if (s_q.lastSent) begin
            // release the bus one cycle after the last word
            s_d.fsm = FSM_IDLE;
            s_d.adOe = 1'b0;
            s_d.stb.oe = 1'b0;
            s_d.frameN = 1'b1;
          end else if (headValid && (s_q.fsm == FSM_READ || !wbfFull)) begin
            pop = 1'b1;
            s_d.ad = head.data;
            s_d.stb = stbFlip(s_q.stb);
            s_d.lastSent = head.last;
          end
        end
        default: begin
          s_d.fsm = FSM_IDLE;
        end
      endcase
    end
  end

  // link sync and its edge memory reset high: a pin already high at release is no false start
  always_ff @(posedge clock) begin
    if (srst) begin
      s_q <= '{fsm: FSM_IDLE, lnkS: 2'b11, lnkPrev: 1'b1, rbfS: 2'b11, wbfS: 2'b11,
               sbaS1: SBA_IDLE, sbaS2: SBA_IDLE, rbfSeen: 1'b0, wbfSeen: 1'b0,
               lastSent: 1'b0, ad: AD_RESET, adOe: 1'b0,
               stb: '{stb0: 1'b0, stb0N: 1'b1, stb1: 1'b0, stb1N: 1'b1, oe: 1'b0},
               frameN: 1'b1, gntN: 1'b1, st: ST_RESET, sbaReq: 1'b0,
               sbaAddr: SBA_IDLE};
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register, except frameOe which is tied high
  assign adOut = s_q.ad;
  assign adOe = s_q.adOe;
  assign adStb = s_q.stb;
  assign frameN = s_q.frameN;
  assign frameOe = 1'b1;
  assign gntN = s_q.gntN;
  assign stOut = s_q.st;
  assign sbaReq = s_q.sbaReq;
  assign sbaAddr = s_q.sbaAddr;

  // ****************************************
  // checks
  // ****************************************
  sequence readStart;
    s_q.fsm == FSM_IDLE && s_d.fsm == FSM_READ;
  endsequence
  sequence writeStart;
    s_q.fsm == FSM_IDLE && s_d.fsm == FSM_WRITE;
  endsequence

  a_read_blocked: assert property (@(posedge clock) disable iff (srst)
    readStart |-> !(flowOn && s_q.rbfSeen)) else $error("read started while full");
  a_flag_sample: assert property (@(posedge clock) disable iff (srst)
    !rise |=> $stable(s_q.rbfSeen) && $stable(s_q.wbfSeen)) else $error("flag sampled late");
  a_frame_ignore: assert property (@(posedge clock) disable iff (srst)
    (mode == MODE_FRAME && rise && s_q.fsm == FSM_IDLE && headValid)
    |=> s_q.fsm != FSM_IDLE) else $error("flag honoured in frame mode");
  a_write_blocked: assert property (@(posedge clock) disable iff (srst)
    (pop && head.isWrite) |-> !wbfFull) else $error("write data while full");
  a_frame_bracket: assert property (@(posedge clock) disable iff (srst)
    writeStart |=> !frameN ##0 (s_q.fsm == FSM_WRITE)) else $error("frame not low");
  a_frame_idle: assert property (@(posedge clock) disable iff (srst)
    s_q.fsm != FSM_WRITE |-> frameN) else $error("frame low outside write");
  a_strobe_step: assert property (@(posedge clock) disable iff (srst)
    pop |=> adStb.oe && adOe && (adStb.stb0 != $past(adStb.stb0))
    && (adStb.stb1N == $past(adStb.stb1))) else $error("strobe not stepped");
  a_status_go: assert property (@(posedge clock) disable iff (srst)
    (mode == MODE_FRAME && frameGrant) |=> stOut == ST_FRAME_GO) else $error("no go status");
  a_sba_quiet: assert property (@(posedge clock) disable iff (srst)
    (mode == MODE_FRAME) [*2] |-> !sbaReq) else $error("sideband used in frame mode");
endmodule // ahfs_host

`default_nettype wire

//--- testbench/ahfs_master_model.sv
// master-side model: link clock, buffer-full pins, sideband pins, status capture
`timescale 1ns/10ps
`default_nettype none
module ahfs_master_model (
  input wire logic rbfFull,
  input wire logic wbfFull,
  input wire logic [7:0] sbaVal,
  input wire logic gntN,
  input wire logic [2:0] stOut,
  output logic linkClk,
  output logic rbfN,
  output logic wbfN,
  output logic [7:0] sbaIn,
  output logic [2:0] stSeen
);
  // link clock runs free, 320 ns, no phase tie to the system clock
  initial linkClk = 1'b0;
  always #160 linkClk = ~linkClk;
  // full pins are low only while the bench says the buffer is full
  assign rbfN = ~rbfFull;
  assign wbfN = ~wbfFull;
  // sideband moves on the falling link edge so it is settled at the rise
  // no sideband strobe pin exists on the block, so none is modelled
  initial sbaIn = 8'hFF;
  always @(negedge linkClk) sbaIn <= sbaVal;
  // status taken only while granted, ignored otherwise
  always @(posedge linkClk) if (!gntN) stSeen <= stOut;
endmodule // ahfs_master_model
`default_nettype wire

//--- testbench/tb_top.sv
// self-checking bench for the host engine against the master model
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import ahfs_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  ahfs_mode_t mode = MODE_PIPE;
  logic rbfFull = 1'b0;
  logic wbfFull = 1'b0;
  logic [7:0] sbaVal = 8'hFF;
  logic grantReq = 1'b0;
  logic frameGrant = 1'b0;
  logic [2:0] stCode = 3'h0;
  logic wordValid = 1'b0;
  ahfs_word_t wordIn = '0;
  logic linkClk, rbfN, wbfN, wordReady, adOe, frameN, frameOe, gntN, sbaReq;
  logic [7:0] sbaIn, sbaAddr;
  logic [2:0] stSeen, stOut;
  logic [31:0] adOut;
  ahfs_strobe_t adStb;
  int fails = 0;
  int checks = 0;
  int i;
  int n;

  always #20 clock = ~clock;

  ahfs_master_model ahfs_master_model_i (.rbfFull(rbfFull), .wbfFull(wbfFull),
    .sbaVal(sbaVal), .gntN(gntN), .stOut(stOut), .linkClk(linkClk), .rbfN(rbfN),
    .wbfN(wbfN), .sbaIn(sbaIn), .stSeen(stSeen));
  ahfs_host ahfs_host_i (.clock(clock), .srst(srst), .mode(mode), .linkClk(linkClk),
    .rbfN(rbfN), .wbfN(wbfN), .sbaIn(sbaIn), .grantReq(grantReq),
    .frameGrant(frameGrant), .stCode(stCode), .wordValid(wordValid),
    .wordReady(wordReady), .wordIn(wordIn), .adOut(adOut), .adOe(adOe),
    .adStb(adStb), .frameN(frameN), .frameOe(frameOe), .gntN(gntN),
    .stOut(stOut), .sbaReq(sbaReq), .sbaAddr(sbaAddr));

  // **********
  // shared tasks
  // **********
  task automatic tick();
    @(posedge clock);
    #1;
  endtask
  task automatic close_out();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] a, input logic [31:0] e);
    checks++;
    if (a !== e) begin
      fails++;
      $display("mismatch t=%0t got %h exp %h", $time, a, e);
    end
  endtask
  task automatic cmpBit(input logic a, input logic e);
    cmp(32'(a), 32'(e));
  endtask
  // valid is left high; the caller drops it after a run of words
  task automatic push(input logic wr, input logic lst, input logic [31:0] d);
    wordIn = {wr, lst, d};
    wordValid = 1'b1;
    tick();
  endtask
  function automatic logic [31:0] pick(input int k);
    return k == 0 ? 32'(adOe) : k == 1 ? adOut : 32'(sbaReq);
  endfunction
  // bounded wait; a hang counts as a mismatch and ends the run
  task automatic waitOn(input int k, input logic [31:0] v);
    int c;
    for (c = 0; c < 400 && pick(k) !== v; c++) tick();
    if (c == 400) begin
      fails++;
      close_out();
    end
  endtask

  // **********
  // scenarios
  // **********
  task automatic t_reset();
    cmpBit(adOe, 1'b0);
    cmp(adStb, 5'b01010);
    cmpBit(frameN, 1'b1);
    cmpBit(frameOe, 1'b1);
    cmp({gntN, stOut, sbaReq}, 5'b11110);
    cmp(sbaAddr, 8'hFF);
    cmpBit(wordReady, 1'b1);
    $display("t_reset done");
  endtask
  task automatic t_write();
    push(1'b1, 1'b0, 32'hAAAA_0001);
    push(1'b1, 1'b1, 32'hAAAA_0002);
    wordValid = 1'b0;
    waitOn(0, 1);
    cmp(adOut, 32'hAAAA_0001);
    cmpBit(frameN, 1'b0);
    cmp(adStb, 5'b10101);
    waitOn(1, 32'hAAAA_0002);
    cmp(adStb, 5'b01011);
    waitOn(0, 0);
    cmp({frameN, adStb.oe}, 2'b10);
    $display("t_write done");
  endtask
  task automatic t_readHeld();
    rbfFull = 1'b1;
    repeat (40) tick();
    push(1'b0, 1'b1, 32'h1234_5678);
    wordValid = 1'b0;
    repeat (40) tick();
    cmpBit(adOe, 1'b0);
    rbfFull = 1'b0;
    waitOn(0, 1);
    cmp({frameN, adOut}, {1'b1, 32'h1234_5678});
    waitOn(0, 0);
    $display("t_readHeld done");
  endtask
  task automatic t_frameIgnore();
    mode = MODE_FRAME;
    rbfFull = 1'b1;
    wbfFull = 1'b1;
    push(1'b0, 1'b1, 32'h0BAD_F00D);
    wordValid = 1'b0;
    waitOn(0, 1);
    cmp(adOut, 32'h0BAD_F00D);
    waitOn(0, 0);
    push(1'b1, 1'b1, 32'hFEED_0001);
    wordValid = 1'b0;
    waitOn(0, 1);
    cmp({frameN, adOut}, {1'b0, 32'hFEED_0001});
    waitOn(0, 0);
    rbfFull = 1'b0;
    wbfFull = 1'b0;
    $display("t_frameIgnore done");
  endtask
  task automatic t_fill();
    mode = MODE_SBA;
    wbfFull = 1'b1;
    repeat (40) tick();
    for (i = 0; i < 32; i++) push(1'b1, i == 31, 32'h5000_0000 + i);
    wordValid = 1'b0;
    tick();
    cmpBit(wordReady, 1'b0);
    cmpBit(adOe, 1'b0);
    wbfFull = 1'b0;
    for (i = 0; i < 32; i++) waitOn(1, 32'h5000_0000 + i);
    cmp({adOe, frameN}, 2'b10);
    waitOn(0, 0);
    cmpBit(wordReady, 1'b1);
    $display("t_fill done");
  endtask
  task automatic t_status();
    mode = MODE_FRAME;
    frameGrant = 1'b1;
    stCode = 3'h2;
    repeat (20) tick();
    cmp({gntN, stOut, stSeen}, 7'b0111111);
    mode = MODE_PIPE;
    frameGrant = 1'b0;
    grantReq = 1'b1;
    repeat (20) tick();
    cmp({gntN, stOut, stSeen}, 7'b0010010);
    grantReq = 1'b0;
    stCode = 3'h5;
    repeat (20) tick();
    cmp({gntN, stOut, stSeen}, 7'b1101010);
    $display("t_status done");
  endtask
  task automatic t_sideband();
    mode = MODE_SBA;
    for (i = 0; i < 4; i++) push(1'b1, i == 3, 32'h6000_0000 + i);
    wordValid = 1'b0;
    waitOn(0, 1);
    sbaVal = 8'h3C;
    waitOn(2, 1);
    cmp({adOe, sbaAddr}, {1'b1, 8'h3C});
    sbaVal = 8'hFF;
    waitOn(0, 0);
    cmpBit(sbaReq, 1'b0);
    mode = MODE_FRAME;
    tick();
    sbaVal = 8'hC3;
    n = 0;
    repeat (48) begin
      tick();
      n += sbaReq;
    end
    cmp(n, 0);
    sbaVal = 8'hFF;
    $display("t_sideband done");
  endtask

  // reset for six cycles, reset values checked while still held, then every scenario
  initial begin
    repeat (6) tick();
    t_reset();
    srst = 1'b0;
    tick();
    t_write();
    t_readHeld();
    t_frameIgnore();
    t_fill();
    t_status();
    t_sideband();
    close_out();
  end
endmodule // tb_top
`default_nettype wire
